// ---- bench/rsr_receiver_asserts.sv ----
// Port checker for the radio serial receiver.
// Assumes it is bound to rsr_receiver; one clock, reset active low.
`include "rsr_defines.svh"
module rsr_receiver_asserts (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire rsr_pkg::rsr_resp_t s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire rsr_pkg::rsr_word_t s_axi_rdata,
  input wire rsr_pkg::rsr_resp_t s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt
  input wire logic rx_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  import rsr_pkg::*;
  // Everything here is sampled on the one system clock
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // Read address taken
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Address and data of a write taken together
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Read completes, then the address channel reopens
  sequence s_rd_close;
    !s_axi_rvalid ##[0:1] s_axi_arready;
  endsequence
  a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
    else $error("read answer missing");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer not held");
  a_read_close: assert property (s_axi_rvalid && s_axi_rready |=>
    s_rd_close) else $error("read not closed");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  a_slverr_zero: assert property (s_axi_rvalid &&
    s_axi_rresp == `RSR_RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("refused read carries data");
  // The held pair is seen one cycle after the handshake, then answered
  a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("write answer missing");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer not held");
  a_write_busy: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  a_irq_pulse: assert property (rx_irq |=> !rx_irq)
    else $error("interrupt longer than one cycle");
  a_reset_quiet: assert property ($rose(rst_n) |->
    !s_axi_bvalid && !s_axi_rvalid && !rx_irq)
    else $error("outputs active after reset");
endmodule

bind rsr_receiver rsr_receiver_asserts i_rsr_receiver_asserts (
  .sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .rx_irq(rx_irq));

// ---- bench/rsr_receiver_tb.sv ----
// Self-checking bench for the radio serial receiver.
// Assumes the transceiver model and the port checker sit beside it.
`include "rsr_defines.svh"
module rsr_receiver_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import rsr_pkg::*;
  // Symbol length: 16 x 13 x 8 cycles with the halved external clock
  localparam int NRZ_N = 1664;
  localparam int MAN_N = 40; // Short symbols paced by the bit clock
  localparam logic [7:0] MSG [4] = '{8'hA5, 8'h00, 8'hFF, 8'h3C};
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  rsr_word_t s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  rsr_resp_t s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = 12'h000;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  rsr_word_t s_axi_rdata;
  rsr_resp_t s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic rx_data;
  logic bit_clk;
  logic pattern;
  logic ext_clk;
  logic rx_irq;
  int fails = 0;
  int n_tests = 0;
  int irq_cnt = 0;
  logic lvl = 1'b0; // Line level of the mark-coded stream
  always #4 sys_clk = ~sys_clk;
  // Count interrupt pulses; their width is left to the checker
  always @(posedge sys_clk)
    if (rx_irq === 1'b1) irq_cnt <= irq_cnt + 1;
  rsr_receiver i_rsr_receiver (.sys_clk(sys_clk), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .radio_rx_data_pin(rx_data),
    .radio_bit_clock_pin(bit_clk), .radio_pattern_pin(pattern),
    .ext_clk_pin(ext_clk), .rx_irq(rx_irq));
  rsr_xcvr_model i_rsr_xcvr_model (.sys_clk(sys_clk),
    .radio_rx_data_pin(rx_data), .radio_bit_clock_pin(bit_clk),
    .radio_pattern_pin(pattern), .ext_clk_pin(ext_clk));
  // Verdict and end of run
  task automatic summarize;
    if (fails == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // One comparison
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input rsr_word_t d,
                    input logic [3:0] s, input rsr_resp_t er);
    int n;
    logic aw_d;
    logic w_d;
    logic b_d;
    rsr_resp_t r;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    aw_d = 1'b0;
    w_d = 1'b0;
    b_d = 1'b0;
    while (!b_d && n < 100) begin
      @(posedge sys_clk);
      n++;
      if (!aw_d && s_axi_awready) begin
        aw_d = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_d && s_axi_wready) begin
        w_d = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1) begin
        b_d = 1'b1;
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
    if (!b_d) begin
      fails++;
      summarize();
    end
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask
  // Read and compare data and response
  task automatic rdc(input logic [11:0] a, input rsr_word_t e,
                     input rsr_resp_t er);
    int n;
    logic a_d;
    logic r_d;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    a_d = 1'b0;
    r_d = 1'b0;
    while (!r_d && n < 100) begin
      @(posedge sys_clk);
      n++;
      if (!a_d && s_axi_arready) begin
        a_d = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid === 1'b1) begin
        r_d = 1'b1;
        chk("rdata", e, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        s_axi_rready <= 1'b0;
      end
    end
    if (!r_d) begin
      fails++;
      summarize();
    end
  endtask
  // Mark-coded byte, MSB first; a one is a change of level
  task automatic nrz_byte(input logic [7:0] b, input logic pat);
    for (int i = 7; i >= 0; i--) begin
      lvl = lvl ^ b[i];
      i_rsr_xcvr_model.sym(lvl, NRZ_N, 3, pat && i == 7);
    end
  endtask
  // Manchester byte, MSB first; a one is the pair 10
  task automatic man_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      i_rsr_xcvr_model.sym(b[i], MAN_N, 1, 1'b0);
      i_rsr_xcvr_model.sym(~b[i], MAN_N, 1, 1'b0);
    end
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdc(`RSR_ADDR_CTRL, 32'h0, `RSR_RESP_OKAY);
    rdc(`RSR_ADDR_BAUD, 32'h0, `RSR_RESP_OKAY);
    rdc(`RSR_ADDR_SYSCLK, 32'h0, `RSR_RESP_OKAY);
    rdc(`RSR_ADDR_STATUS, 32'h0, `RSR_RESP_OKAY);
    rdc(12'h020, 32'h0, `RSR_RESP_SLVERR);
    wr(12'h020, 32'hFFFFFFFF, 4'hF, `RSR_RESP_SLVERR);
    // Manchester, bit clock, start on a code violation
    wr(`RSR_ADDR_CTRL, 32'h300, 4'h2, `RSR_RESP_OKAY);
    wr(`RSR_ADDR_CTRL, 32'h5D, 4'h1, `RSR_RESP_OKAY);
    rdc(`RSR_ADDR_CTRL, 32'h35D, `RSR_RESP_OKAY);
    i_rsr_xcvr_model.sym(1'b1, MAN_N, 1, 1'b0);
    i_rsr_xcvr_model.sym(1'b1, MAN_N, 1, 1'b0);
    chk("irq count", 32'd1, irq_cnt);
    man_byte(8'h96);
    rdc(`RSR_ADDR_STATUS, 32'h12, `RSR_RESP_OKAY);
    i_rsr_xcvr_model.sym(1'b0, MAN_N, 1, 1'b0);
    i_rsr_xcvr_model.sym(1'b0, MAN_N, 1, 1'b0);
    man_byte(8'h4B);
    rdc(`RSR_ADDR_STATUS, 32'h12, `RSR_RESP_OKAY);
    chk("irq count", 32'd2, irq_cnt);
    rdc(`RSR_ADDR_RXDATA, 32'h4B, `RSR_RESP_OKAY);
    rdc(`RSR_ADDR_RXDATA, 32'h0, `RSR_RESP_OKAY);
    // Reset again in mid-run
    rst_n <= 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdc(`RSR_ADDR_CTRL, 32'h0, `RSR_RESP_OKAY);
    // Mark code, halved external clock, divider 13, pattern pin start
    wr(`RSR_ADDR_SYSCLK, 32'h1, 4'hF, `RSR_RESP_OKAY);
    wr(`RSR_ADDR_BAUD, 32'hC, 4'hF, `RSR_RESP_OKAY);
    wr(`RSR_ADDR_CTRL, 32'h200, 4'h2, `RSR_RESP_OKAY);
    wr(`RSR_ADDR_CTRL, 32'h8D, 4'h1, `RSR_RESP_OKAY);
    repeat (2) begin
      lvl = ~lvl;
      i_rsr_xcvr_model.sym(lvl, NRZ_N, 3, 1'b0);
    end
    nrz_byte(MSG[0], 1'b1);
    chk("irq count", 32'd3, irq_cnt);
    wr(`RSR_ADDR_CTRL, 32'h800, 4'h2, `RSR_RESP_OKAY);
    wr(`RSR_ADDR_STATUS, 32'h1, 4'hF, `RSR_RESP_OKAY);
    rdc(`RSR_ADDR_STATUS, 32'h12, `RSR_RESP_OKAY);
    for (int i = 1; i < 4; i++) nrz_byte(MSG[i], 1'b0);
    chk("irq count", 32'd4, irq_cnt);
    nrz_byte(8'h81, 1'b0);
    chk("irq count", 32'd4, irq_cnt);
    rdc(`RSR_ADDR_STATUS, 32'h19, `RSR_RESP_OKAY);
    for (int i = 0; i < 4; i++)
      rdc(`RSR_ADDR_RXDATA, {24'h0, MSG[i]}, `RSR_RESP_OKAY);
    rdc(`RSR_ADDR_STATUS, 32'h11, `RSR_RESP_OKAY);
    // Back to start interrupts; space code paced by the bit clock
    wr(`RSR_ADDR_CTRL, 32'h300, 4'h2, `RSR_RESP_OKAY);
    wr(`RSR_ADDR_CTRL, 32'h95, 4'h1, `RSR_RESP_OKAY);
    for (int i = 7; i >= 0; i--) begin
      lvl = lvl ^ ~MSG[3][i];
      i_rsr_xcvr_model.sym(lvl, MAN_N, 1, i == 7);
    end
    chk("irq count", 32'd5, irq_cnt);
    rdc(`RSR_ADDR_RXDATA, {24'h0, MSG[3]}, `RSR_RESP_OKAY);
    summarize();
  end
endmodule

// ---- bench/rsr_xcvr_model.sv ----
// Behavioural model of the radio transceiver's receive outputs.
// Assumes the bench calls sym once per line symbol, in order.
module rsr_xcvr_model (
  // Clock that times the symbols
  input wire logic sys_clk,
  // Transceiver outputs
  output logic radio_rx_data_pin,
  output logic radio_bit_clock_pin,
  output logic radio_pattern_pin,
  output logic ext_clk_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // Clock output runs free, phase unrelated to the system clock
  initial begin
    radio_rx_data_pin = 1'b0;
    radio_bit_clock_pin = 1'b0;
    radio_pattern_pin = 1'b0;
    ext_clk_pin = 1'b0;
    #3;
    forever #16 ext_clk_pin = ~ext_clk_pin;
  end
  // One symbol of n cycles, k bit-clock pulses, optional pattern flag.
  // The bit clock only moves inside a symbol, so it idles between frames.
  task automatic sym(input logic lvl, input int n, input int k,
                     input logic pat);
    int m;
    int ph;
    m = n / k;
    for (int c = 0; c < n; c++) begin
      @(posedge sys_clk);
      ph = c % m;
      radio_rx_data_pin <= lvl;
      radio_bit_clock_pin <= (ph >= m / 2) && (ph < m / 2 + m / 4);
      radio_pattern_pin <= pat && (c < 16);
    end
  endtask
endmodule

// ---- inc/rsr_defines.svh ----
// Constants for the radio serial receiver: register map, field
// positions, line codes and divider figures.
// Assumes a 32-bit AXI4-Lite register bus and one system clock.
`ifndef RSR_DEFINES_SVH
`define RSR_DEFINES_SVH

// Register byte addresses
`define RSR_ADDR_CTRL 12'h000
`define RSR_ADDR_BAUD 12'h004
`define RSR_ADDR_SYSCLK 12'h008
`define RSR_ADDR_STATUS 12'h00C
`define RSR_ADDR_RXDATA 12'h010
`define RSR_ADDR_W 12

// Control register fields
`define RSR_CTRL_RXEN 0
`define RSR_CTRL_TXEN 1
`define RSR_CTRL_CODEC 2
`define RSR_CTRL_CODE_LO 3
`define RSR_CTRL_CODE_HI 5
`define RSR_CTRL_START_LO 6
`define RSR_CTRL_START_HI 7
`define RSR_CTRL_BITCLK 8
`define RSR_CTRL_IRQ_LO 9
`define RSR_CTRL_IRQ_HI 11

// Baud register fields
`define RSR_BAUD_FINE_LO 0
`define RSR_BAUD_FINE_HI 3
`define RSR_BAUD_COARSE_LO 4
`define RSR_BAUD_COARSE_HI 5

// Status register fields
`define RSR_STAT_OVR 0
`define RSR_STAT_CNT_LO 1
`define RSR_STAT_CNT_HI 3
`define RSR_STAT_SYNC 4

// System clock register field
`define RSR_SYSCLK_EXT 0

// Line codes, start modes, interrupt sources
`define RSR_CODE_NRZ_LEVEL 3'h0
`define RSR_CODE_NRZ_MARK 3'h1
`define RSR_CODE_NRZ_SPACE 3'h2
`define RSR_CODE_MAN_LEVEL 3'h3
`define RSR_START_PATTERN 2'h2
`define RSR_START_VIOL 2'h1
`define RSR_IRQ_START 3'h1
`define RSR_IRQ_FULL 3'h4

// Coarse divider factors
`define RSR_COARSE_0 5'h01
`define RSR_COARSE_1 5'h04
`define RSR_COARSE_2 5'h08
`define RSR_COARSE_3 5'h10

// Oversampling: 16 ticks per symbol, sample at the middle
`define RSR_OS_MID 4'h7
`define RSR_FIFO_DEPTH 3'h4
`define RSR_RESP_OKAY 2'h0
`define RSR_RESP_SLVERR 2'h2

`endif

// ---- inc/rsr_pkg.sv ----
// Types shared by the radio serial receiver.
// Constants live in rsr_defines.svh.
package rsr_pkg;
  typedef logic [7:0] rsr_byte_t;      // One received byte
  typedef logic [1:0] rsr_ptr_t;       // FIFO slot index
  typedef logic [2:0] rsr_count_t;     // FIFO fill level 0..4
  typedef logic [8:0] rsr_div_t;       // Divider product 1..256
  typedef logic [31:0] rsr_word_t;     // Bus data word
  typedef logic [1:0] rsr_resp_t;      // Bus response code
endpackage

// ---- src/rsr_receiver.sv ----
// Receive path of a radio serial interface: baud generator, line
// decoder, start-sequence detector, four-byte FIFO, AXI4-Lite slave.
// Assumes pins arrive asynchronously and sys_clk runs at 125 MHz.
`include "rsr_defines.svh"

// What this block does
// R1: Software enables receive, disables transmit first
// R2: Symbol rate is clock over 16 times product
// R3: Fine code 1100 with coarse 00 gives 13
// R4: External clock selected is divided by two
// R5: Bit clock select 0 uses internal generator
// R6: Decoder applies NRZ mark or Manchester level
// R7: Start from pattern pin or code violation
// R8: Interrupt on start detect or FIFO full
// R9: Four-byte FIFO, data read pops oldest
// R10: Software reads four bytes per full interrupt
// R11: Byte arriving at full FIFO sets overrun
// R12: Start detection flushes the FIFO
// R13: Data before first start is meaningless
// R14: Software switches interrupt to FIFO full
// R15: Software returns interrupt to start detect
// R16: Software enables interrupt in system handler
// R17: Manchester divider programmed for symbol rate
// R18: Data and bit clock pins from transceiver
// R19: Pattern pin from transceiver pattern output
// R20: Manchester violation is start, aligns bytes
// R21: Interrupt is a one-cycle pulse on condition
module rsr_receiver (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // AXI4-Lite write address
  input wire logic [`RSR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire rsr_pkg::rsr_word_t s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output rsr_pkg::rsr_resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [`RSR_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output rsr_pkg::rsr_word_t s_axi_rdata,
  output rsr_pkg::rsr_resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Transceiver pins
  input wire logic radio_rx_data_pin,
  input wire logic radio_bit_clock_pin,
  input wire logic radio_pattern_pin,
  input wire logic ext_clk_pin,
  // Receive interrupt request
  output logic rx_irq
);
  import rsr_pkg::*;

  // Configuration held by software
  logic rx_enable_bit, tx_enable_bit, codec_enable_bit;
  logic [2:0] line_code_field;
  logic [1:0] start_detect_mode;
  logic rx_bitclock_select;
  logic [2:0] rx_irq_source;
  logic [3:0] baud_fine_field;
  logic [1:0] baud_coarse_field;
  logic ext_clock_select;

  // Bus side state
  logic aw_held_q, w_held_q;
  logic [`RSR_ADDR_W-1:0] awaddr_q;
  rsr_word_t wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire, rd_fire, pop;

  // Pin synchronisers: first stage read only by the second
  logic [3:0] sync1_q, sync2_q, sync3_q;
  logic data_s, data_edge, bclk_rise, pat_rise, ext_rise;
  assign data_s = sync2_q[0];
  assign data_edge = sync2_q[0] ^ sync3_q[0];
  assign bclk_rise = sync2_q[1] & ~sync3_q[1];
  assign pat_rise = sync2_q[2] & ~sync3_q[2];
  assign ext_rise = sync2_q[3] & ~sync3_q[3];

  // Receive datapath state
  logic ext_half_q, base_tick;
  rsr_div_t presc_q, prod;
  logic [3:0] os_q;
  logic os_tick, sym_tick;
  logic prev_sym_q, half_q, phase_q;
  logic bit_valid, bit_val, viol, start_evt;
  rsr_byte_t shift_q;
  logic [2:0] bitcnt_q;
  logic byte_done;
  logic synced_q, rx_overrun_flag, full_q;

  // FIFO storage
  rsr_byte_t fifo_q [0:3];
  rsr_ptr_t wr_ptr_q, rd_ptr_q;
  rsr_count_t count_q;
  logic push;

  // Synchronise every pin through two flops, keep a third for edges
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      sync3_q <= 4'h0;
    end else begin
      sync1_q <= {ext_clk_pin, radio_pattern_pin, radio_bit_clock_pin,
                  radio_rx_data_pin};  // R18 R19
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // External clock halved: every second rising edge is one base tick
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_half_q <= 1'b0;
    end else if (ext_rise) begin
      ext_half_q <= ~ext_half_q;  // R4
    end
  end
  assign base_tick = ext_clock_select ? (ext_rise & ext_half_q)
                                      : 1'b1;  // R4

  // Divider product: fine code plus one times the coarse factor
  always_comb begin
    logic [4:0] coarse;
    coarse = `RSR_COARSE_0;
    case (baud_coarse_field)
      2'h0: coarse = `RSR_COARSE_0;
      2'h1: coarse = `RSR_COARSE_1;
      2'h2: coarse = `RSR_COARSE_2;
      default: coarse = `RSR_COARSE_3;
    endcase
    // Nine-bit arithmetic: the largest product, 16 x 16, needs all nine
    prod = (9'(baud_fine_field) + 9'h001) * 9'(coarse);  // R2 R3
  end

  // Prescaler gives the 16x oversampling tick
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_q <= 9'h000;
    end else if (!rx_enable_bit) begin
      presc_q <= 9'h000;
    end else if (base_tick) begin
      presc_q <= (presc_q >= prod - 9'h001) ? 9'h000
                                           : presc_q + 9'h001;  // R2
    end
  end
  assign os_tick = base_tick && (presc_q >= prod - 9'h001);

  // Oversample phase, realigned on every line edge so that the
  // symbol is taken mid-cell even with a drifting transmitter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      os_q <= 4'h0;
    end else if (!rx_enable_bit || data_edge) begin
      os_q <= 4'h0;
    end else if (os_tick) begin
      os_q <= os_q + 4'h1;
    end
  end

  // Symbol strobe: internal generator or the transceiver bit clock
  assign sym_tick = rx_enable_bit &&
    (rx_bitclock_select ? bclk_rise
                        : (os_tick && os_q == `RSR_OS_MID));  // R5

  // Line decoder: turns symbols into bits, flags code violations
  always_comb begin
    bit_valid = 1'b0;
    bit_val = data_s;
    viol = 1'b0;
    if (sym_tick) begin
      if (!codec_enable_bit) begin
        bit_valid = 1'b1;
      end else begin
        case (line_code_field)
          `RSR_CODE_NRZ_MARK: begin
            bit_valid = 1'b1;
            bit_val = data_s ^ prev_sym_q;  // R6
          end
          `RSR_CODE_NRZ_SPACE: begin
            bit_valid = 1'b1;
            bit_val = ~(data_s ^ prev_sym_q);
          end
          `RSR_CODE_MAN_LEVEL: begin
            // Second half of a pair: 10 is one, 01 is zero
            if (phase_q) begin
              bit_valid = (half_q != data_s);  // R6
              bit_val = half_q;
              viol = (half_q == data_s);  // R20
            end
          end
          default: begin
            bit_valid = 1'b1;
          end
        endcase
      end
    end
  end

  // Symbol history and Manchester pair phase
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_sym_q <= 1'b0;
      half_q <= 1'b0;
      phase_q <= 1'b0;
    end else if (!rx_enable_bit) begin
      phase_q <= 1'b0;
    end else if (sym_tick) begin
      prev_sym_q <= data_s;
      half_q <= data_s;
      // A violating pair restarts pairing at the next symbol
      phase_q <= viol ? 1'b0 : ~phase_q;  // R20
    end
  end

  // Start detection from the pattern pin or a code violation
  always_comb begin
    case (start_detect_mode)
      `RSR_START_PATTERN: start_evt = rx_enable_bit & pat_rise;  // R7
      `RSR_START_VIOL: start_evt = viol;  // R7
      default: start_evt = 1'b0;
    endcase
  end

  // Byte assembly, MSB first; start resets the byte boundary
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= 8'h00;
      bitcnt_q <= 3'h0;
    end else if (start_evt || !rx_enable_bit) begin
      shift_q <= 8'h00;
      bitcnt_q <= 3'h0;  // R20
    end else if (bit_valid) begin
      shift_q <= {shift_q[6:0], bit_val};
      bitcnt_q <= bitcnt_q + 3'h1;
    end
  end
  assign byte_done = bit_valid && !start_evt && bitcnt_q == 3'h7;

  // FIFO push and pop; a start flush beats both
  assign push = byte_done && count_q != `RSR_FIFO_DEPTH;  // R11
  assign pop = rd_fire && count_q != 3'h0 &&
               s_axi_araddr == `RSR_ADDR_RXDATA;  // R9
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= 2'h0;
      rd_ptr_q <= 2'h0;
      count_q <= 3'h0;
    end else if (start_evt) begin
      wr_ptr_q <= 2'h0;
      rd_ptr_q <= 2'h0;
      count_q <= 3'h0;  // R12
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 2'h1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 2'h1;  // R9
      end
      count_q <= count_q + 3'(push) - 3'(pop);
    end
  end

  // FIFO storage written at the write pointer
  always_ff @(posedge sys_clk) begin
    if (push) begin
      fifo_q[wr_ptr_q] <= {shift_q[6:0], bit_val};  // R9
    end
  end

  // Overrun and synced flags; hardware set beats software clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_overrun_flag <= 1'b0;
      synced_q <= 1'b0;
    end else begin
      if (byte_done && count_q == `RSR_FIFO_DEPTH) begin
        rx_overrun_flag <= 1'b1;  // R11
      end else if (wr_fire && awaddr_q == `RSR_ADDR_STATUS &&
                   wstrb_q[0] && wdata_q[`RSR_STAT_OVR]) begin
        rx_overrun_flag <= 1'b0;
      end
      if (start_evt) begin
        synced_q <= 1'b1;
      end else if (!rx_enable_bit) begin
        synced_q <= 1'b0;
      end
    end
  end

  // Interrupt pulse when the chosen condition first holds
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      full_q <= 1'b0;
      rx_irq <= 1'b0;
    end else begin
      full_q <= (count_q == `RSR_FIFO_DEPTH);
      case (rx_irq_source)
        `RSR_IRQ_START: rx_irq <= start_evt;  // R8 R21
        `RSR_IRQ_FULL: rx_irq <= (count_q == `RSR_FIFO_DEPTH) &&
                                 !full_q;  // R8 R21
        default: rx_irq <= 1'b0;
      endcase
    end
  end

  // Write channel: address and data taken in either order
  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RSR_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q <= `RSR_ADDR_RXDATA &&
                        awaddr_q[1:0] == 2'h0) ? `RSR_RESP_OKAY
                                               : `RSR_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
      end
    end
  end

  // Configuration registers; control lane 1 is taken only when lane 0 is not strobed
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {start_detect_mode, line_code_field, codec_enable_bit} <= '0;
      {tx_enable_bit, rx_enable_bit} <= 2'h0;
      {rx_irq_source, rx_bitclock_select} <= 4'h0;
      {baud_coarse_field, baud_fine_field} <= 6'h00;
      ext_clock_select <= 1'b0;
    end else if (wr_fire && wstrb_q[0]) begin
      if (awaddr_q == `RSR_ADDR_CTRL) begin
        rx_enable_bit <= wdata_q[`RSR_CTRL_RXEN];
        tx_enable_bit <= wdata_q[`RSR_CTRL_TXEN];
        codec_enable_bit <= wdata_q[`RSR_CTRL_CODEC];
        line_code_field <= wdata_q[`RSR_CTRL_CODE_HI:`RSR_CTRL_CODE_LO];
        start_detect_mode <=
          wdata_q[`RSR_CTRL_START_HI:`RSR_CTRL_START_LO];
      end
      if (awaddr_q == `RSR_ADDR_BAUD) begin
        baud_fine_field <= wdata_q[`RSR_BAUD_FINE_HI:`RSR_BAUD_FINE_LO];
        baud_coarse_field <=
          wdata_q[`RSR_BAUD_COARSE_HI:`RSR_BAUD_COARSE_LO];
      end
      if (awaddr_q == `RSR_ADDR_SYSCLK) begin
        ext_clock_select <= wdata_q[`RSR_SYSCLK_EXT];  // R4
      end
    end else if (wr_fire && wstrb_q[1] && awaddr_q == `RSR_ADDR_CTRL) begin
      rx_bitclock_select <= wdata_q[`RSR_CTRL_BITCLK];
      rx_irq_source <= wdata_q[`RSR_CTRL_IRQ_HI:`RSR_CTRL_IRQ_LO];
    end
  end

  // Read channel: one read in flight, answer one cycle after address
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `RSR_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RSR_RESP_OKAY;
      s_axi_rdata <= '0;
      case (s_axi_araddr)
        `RSR_ADDR_CTRL: s_axi_rdata <= 32'({rx_irq_source,
          rx_bitclock_select, start_detect_mode, line_code_field,
          codec_enable_bit, tx_enable_bit, rx_enable_bit});
        `RSR_ADDR_BAUD: s_axi_rdata <=
          32'({baud_coarse_field, baud_fine_field});
        `RSR_ADDR_SYSCLK: s_axi_rdata <= 32'(ext_clock_select);
        `RSR_ADDR_STATUS: s_axi_rdata <=
          32'({synced_q, count_q, rx_overrun_flag});
        `RSR_ADDR_RXDATA: s_axi_rdata <= (count_q != 3'h0) ?
          32'(fifo_q[rd_ptr_q]) : 32'h0000_0000;  // R9
        default: s_axi_rresp <= `RSR_RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_arready <= !s_axi_rvalid;
    end
  end
endmodule
